/* File: ipc_top.sv */
`timescale 1ns/1ps
`default_nettype none
module ipc_top (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Special function register port
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic [7:0]  sfr_wdata,
  output logic      [7:0]  sfr_rdata,
  // Secondary register port
  input  wire logic [7:0]  sec_addr,
  input  wire logic        sec_wr,
  input  wire logic        sec_rd,
  input  wire logic [7:0]  sec_wdata,
  output logic      [7:0]  sec_rdata,
  // Instruction sequencer
  input  wire logic        first_clock_of_cycle,
  input  wire logic        instr_done,
  input  wire logic        instr_is_reti,
  output logic             irq_take,
  output logic      [15:0] irq_vector,
  output logic             irq_level,
  output logic             active_high,
  output logic             active_low,
  // Timer control
  input  wire logic        timer0_overflow_flag,
  input  wire logic        timer1_overflow_flag,
  input  wire logic        ext0_trigger_type,
  input  wire logic        ext1_trigger_type,
  input  wire logic        ext0_flag_clr,
  input  wire logic        ext1_flag_clr,
  output logic             ext0_flag,
  output logic             ext1_flag,
  // Peripheral events
  input  wire logic [7:0]  flag1_set,
  input  wire logic [7:0]  flag2_set,
  input  wire logic [7:0]  status_set,
  input  wire logic        timer3_config_write,
  input  wire logic        timer2_config_write,
  input  wire logic        watchdog_control_write,
  input  wire logic        scan_start_write,
  // External pins
  input  wire logic        legacy_external_pin_0,
  input  wire logic        legacy_external_pin_1,
  input  wire logic [7:0]  group0_pins,
  input  wire logic        group0_pin8,
  input  wire logic        ext1_pin,
  input  wire logic        ext2_pin,
  input  wire logic        ext3_pin,
  input  wire logic [15:0] ext4_pins
);

  // ==========================================================
  // Pin sampling
  // ==========================================================
  logic [ipc_pkg::PIN_W-1:0] pin_raw, sync1_reg, sync2_reg;
  logic [ipc_pkg::PIN_W-1:0] samp_reg, prev_reg, rise, fall;

  assign pin_raw = {ext4_pins, ext3_pin, ext2_pin, ext1_pin, group0_pin8,
                    group0_pins, legacy_external_pin_1,
                    legacy_external_pin_0};
  assign rise = samp_reg & ~prev_reg;
  assign fall = prev_reg & ~samp_reg;

  // Idle-high reset so no false edge for active-low pins
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync1_reg <= '1;
      sync2_reg <= '1;
      samp_reg  <= '1;
      prev_reg  <= '1;
    end else begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
      if (first_clock_of_cycle) begin
        samp_reg <= sync2_reg;
        prev_reg <= samp_reg;
      end
    end
  end

  function automatic logic pol_hit(input logic [1:0] pol,
                                   input logic r, input logic f);
    case (pol)
      ipc_pkg::POL_FALL: return f;
      ipc_pkg::POL_RISE: return r;
      default:           return r | f;
    endcase
  endfunction : pol_hit

  // ==========================================================
  // Registers and write strobes
  // ==========================================================
  logic [7:0] en0_reg, en1_reg, en2_reg, pri0_reg, pri1_reg, pri2_reg;
  logic [7:0] flag1_reg, flag2_reg, pstat_reg, xstat_reg;
  logic [7:0] sel1_reg, sel2_reg, sel3_reg, sel4_reg, sel5_reg;
  logic [7:0] con1_reg, con2_reg;
  logic [7:0] flag1_next, flag2_next, pstat_next, xstat_next;
  logic [7:0] pstat_clr, pstat_set, xstat_clr, g0_evt;
  logic       w_flag1, w_flag2, w_pstat, w_xstat, w_sel1, w_sel2;
  logic       pin8_evt, ext1_evt, ext2_evt, ext3_evt, ext4_evt;
  logic       leg0_set, leg1_set, ext0_flag_reg, ext1_flag_reg;
  logic [15:0] ext4_sel;

  assign w_flag1 = sfr_wr && sfr_addr == ipc_pkg::ADDR_FLAG1;
  assign w_flag2 = sfr_wr && sfr_addr == ipc_pkg::ADDR_FLAG2;
  assign w_pstat = sfr_wr && sfr_addr == ipc_pkg::ADDR_PSTAT;
  assign w_xstat = sfr_wr && sfr_addr == ipc_pkg::ADDR_XSTAT;
  assign w_sel1  = sec_wr && sec_addr == ipc_pkg::ADDR_SEL1;
  assign w_sel2  = sec_wr && sec_addr == ipc_pkg::ADDR_SEL2;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      en0_reg  <= ipc_pkg::RST_ZERO;
      en1_reg  <= ipc_pkg::RST_ZERO;
      en2_reg  <= ipc_pkg::RST_ZERO;
      pri0_reg <= ipc_pkg::RST_ZERO;
      pri1_reg <= ipc_pkg::RST_ZERO;
      pri2_reg <= ipc_pkg::RST_ZERO;
    end else if (sfr_wr) begin
      case (sfr_addr)
        ipc_pkg::ADDR_EN0:  en0_reg  <= sfr_wdata & ipc_pkg::MASK_EN0;
        ipc_pkg::ADDR_EN1:  en1_reg  <= sfr_wdata & ipc_pkg::MASK_GRP1;
        ipc_pkg::ADDR_EN2:  en2_reg  <= sfr_wdata;
        ipc_pkg::ADDR_PRI0: pri0_reg <= sfr_wdata & ipc_pkg::MASK_PRI0;
        ipc_pkg::ADDR_PRI1: pri1_reg <= sfr_wdata & ipc_pkg::MASK_GRP1;
        ipc_pkg::ADDR_PRI2: pri2_reg <= sfr_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sel1_reg <= ipc_pkg::RST_SEL1;
      sel2_reg <= ipc_pkg::RST_ZERO;
      sel3_reg <= ipc_pkg::RST_ZERO;
      sel4_reg <= ipc_pkg::RST_ZERO;
      sel5_reg <= ipc_pkg::RST_ZERO;
      con1_reg <= ipc_pkg::RST_CON1;
      con2_reg <= ipc_pkg::RST_CON2;
    end else if (sec_wr) begin
      case (sec_addr)
        ipc_pkg::ADDR_SEL1: sel1_reg <= sec_wdata;
        ipc_pkg::ADDR_SEL2: sel2_reg <= sec_wdata;
        ipc_pkg::ADDR_SEL3: sel3_reg <= sec_wdata & ipc_pkg::MASK_SEL3;
        ipc_pkg::ADDR_SEL4: sel4_reg <= sec_wdata;
        ipc_pkg::ADDR_SEL5: sel5_reg <= sec_wdata & ipc_pkg::MASK_SEL5;
        ipc_pkg::ADDR_CON1: con1_reg <= sec_wdata;
        ipc_pkg::ADDR_CON2: con2_reg <= sec_wdata & ipc_pkg::MASK_CON2;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // External events
  // ==========================================================
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      g0_evt[i] = sel2_reg[i] & pol_hit(con2_reg[1:0], rise[2+i],
                                        fall[2+i]);
    end
  end
  assign pin8_evt = sel1_reg[0] & pol_hit(con1_reg[1:0], rise[10], fall[10]);
  assign ext1_evt = sel1_reg[1] & pol_hit(con1_reg[3:2], rise[11], fall[11]);
  assign ext2_evt = sel1_reg[2] & pol_hit(con1_reg[5:4], rise[12], fall[12]);
  assign ext3_evt = sel1_reg[3] & pol_hit(con1_reg[7:6], rise[13], fall[13]);
  assign ext4_sel = {sel5_reg[6:0], sel4_reg, sel3_reg[7]};
  // One vector for the whole group; any armed pin fires it
  assign ext4_evt = |(ext4_sel & (con2_reg[2] ? rise[29:14]
                                              : fall[29:14]));
  // Active low: type 1 follows the low level, type 0 the fall
  assign leg0_set = ext0_trigger_type ? ~samp_reg[0] : fall[0];
  assign leg1_set = ext1_trigger_type ? ~samp_reg[1] : fall[1];

  // ==========================================================
  // Flags and status, set wins over clear
  // ==========================================================
  assign flag1_next = ((w_flag1 ? sfr_wdata : flag1_reg) | flag1_set
                       | {5'h00, ext2_evt, 2'h0}) & ipc_pkg::MASK_GRP1;
  assign flag2_next = (w_flag2 ? sfr_wdata : flag2_reg) | flag2_set
                      | {ext4_evt, ext3_evt, 6'h00};
  assign pstat_clr  = {1'b0, timer3_config_write, w_sel1 & ~sec_wdata[0],
                       watchdog_control_write, timer2_config_write, 1'b0,
                       scan_start_write, scan_start_write};
  assign pstat_set  = {status_set[7:6], pin8_evt, status_set[4:0]}
                      & ipc_pkg::MASK_PSTAT;
  assign pstat_next = (pstat_reg & (w_pstat ? sfr_wdata : 8'hFF)
                       & ~pstat_clr) | pstat_set;
  assign xstat_clr  = w_sel2 ? ~sec_wdata : 8'h00;
  assign xstat_next = (xstat_reg & (w_xstat ? sfr_wdata : 8'hFF)
                       & ~xstat_clr) | g0_evt;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      flag1_reg     <= ipc_pkg::RST_ZERO;
      flag2_reg     <= ipc_pkg::RST_ZERO;
      pstat_reg     <= ipc_pkg::RST_ZERO;
      xstat_reg     <= ipc_pkg::RST_ZERO;
      ext0_flag_reg <= 1'b0;
      ext1_flag_reg <= 1'b0;
    end else begin
      flag1_reg     <= flag1_next;
      flag2_reg     <= flag2_next;
      pstat_reg     <= pstat_next;
      xstat_reg     <= xstat_next;
      // Ext0 also collects the group-0 pins and pin 8
      ext0_flag_reg <= leg0_set | (|g0_evt) | pin8_evt
                       | (ext0_flag_reg & ~ext0_flag_clr);
      ext1_flag_reg <= leg1_set | ext1_evt
                       | (ext1_flag_reg & ~ext1_flag_clr);
    end
  end

  // ==========================================================
  // Priority resolution
  // ==========================================================
  logic [ipc_pkg::NUM_SRC-1:0] pend, pend_lat_reg, enab, prio, req, hi, lo;
  logic [4:0] pick;
  logic       hi_ok, lo_ok, touch, touched_reg, hold_now, do_take;
  logic       act_high_reg, act_low_reg, take_reg, level_reg;
  logic [15:0] vec_reg;
  logic [2:0] call_cnt_reg;
  ipc_pkg::ipc_state_t state_reg, state_next;

  function automatic logic [4:0] first_set(
      input logic [ipc_pkg::NUM_SRC-1:0] v);
    logic [4:0] idx;
    idx = 5'h00;
    for (int i = ipc_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 5'(i);
      end
    end
    return idx;
  endfunction : first_set

  // Query order: ext0, t0, ext1, t1, then group 1, then group 2
  assign pend = {flag2_reg, flag1_reg[7:6], flag1_reg[4:2],
                 timer1_overflow_flag, ext1_flag_reg,
                 timer0_overflow_flag, ext0_flag_reg};
  assign enab = {en2_reg, en1_reg[7:6], en1_reg[4:2],
                 en0_reg[3:0]};
  assign prio = {pri2_reg, pri1_reg[7:6], pri1_reg[4:2],
                 pri0_reg[3:0]};
  assign req  = pend_lat_reg & enab
                & {ipc_pkg::NUM_SRC{en0_reg[ipc_pkg::BIT_GLOBAL_EN]}};
  assign hi   = req & prio;
  assign lo   = req & ~prio;
  assign hi_ok = (|hi) && !act_high_reg;
  assign lo_ok = (|lo) && !act_high_reg && !act_low_reg;
  assign pick  = hi_ok ? first_set(hi) : first_set(lo);

  assign touch = (sfr_wr || sfr_rd)
                 && (sfr_addr == ipc_pkg::ADDR_EN0
                     || sfr_addr == ipc_pkg::ADDR_EN1
                     || sfr_addr == ipc_pkg::ADDR_EN2
                     || sfr_addr == ipc_pkg::ADDR_PRI0
                     || sfr_addr == ipc_pkg::ADDR_PRI1
                     || sfr_addr == ipc_pkg::ADDR_PRI2);
  assign hold_now = instr_is_reti || touched_reg || touch;
  assign do_take  = instr_done && state_reg != ipc_pkg::ST_CALL
                    && !hold_now && (hi_ok || lo_ok);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ipc_pkg::ST_IDLE, ipc_pkg::ST_HOLD: begin
        if (instr_done) begin
          if (hold_now) begin
            state_next = ipc_pkg::ST_HOLD;
          end else if (do_take) begin
            state_next = ipc_pkg::ST_CALL;
          end else begin
            state_next = ipc_pkg::ST_IDLE;
          end
        end
      end
      ipc_pkg::ST_CALL: begin
        if (first_clock_of_cycle && call_cnt_reg == 3'h1) begin
          state_next = ipc_pkg::ST_IDLE;
        end
      end
      default: state_next = ipc_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg    <= ipc_pkg::ST_IDLE;
      pend_lat_reg <= '0;
      touched_reg  <= 1'b0;
      call_cnt_reg <= 3'h0;
    end else begin
      state_reg <= state_next;
      // One cycle of detection before a request can be taken
      if (first_clock_of_cycle) begin
        pend_lat_reg <= pend;
      end
      touched_reg <= !instr_done && (touched_reg || touch);
      if (do_take) begin
        call_cnt_reg <= ipc_pkg::LCALL_CYCLES;
      end else if (first_clock_of_cycle && call_cnt_reg != 3'h0) begin
        call_cnt_reg <= call_cnt_reg - 3'h1;
      end
    end
  end

  // Flags stay set on entry; the routine must clear them
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      take_reg     <= 1'b0;
      level_reg    <= 1'b0;
      vec_reg      <= 16'h0000;
      act_high_reg <= 1'b0;
      act_low_reg  <= 1'b0;
    end else begin
      take_reg <= do_take;
      if (do_take) begin
        level_reg <= hi_ok;
        vec_reg   <= ipc_pkg::ipc_vector(pick);
        if (hi_ok) begin
          act_high_reg <= 1'b1;
        end else begin
          act_low_reg <= 1'b1;
        end
      end else if (instr_done && instr_is_reti) begin
        if (act_high_reg) begin
          act_high_reg <= 1'b0;
        end else begin
          act_low_reg <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // Read ports
  // ==========================================================
  logic [7:0] sfr_mux, sec_mux, sfr_rdata_reg, sec_rdata_reg;
  always_comb begin
    case (sfr_addr)
      ipc_pkg::ADDR_EN0:   sfr_mux = en0_reg;
      ipc_pkg::ADDR_PSTAT: sfr_mux = pstat_reg;
      ipc_pkg::ADDR_PRI0:  sfr_mux = pri0_reg;
      ipc_pkg::ADDR_XSTAT: sfr_mux = xstat_reg;
      ipc_pkg::ADDR_FLAG2: sfr_mux = flag2_reg;
      ipc_pkg::ADDR_EN1:   sfr_mux = en1_reg;
      ipc_pkg::ADDR_EN2:   sfr_mux = en2_reg;
      ipc_pkg::ADDR_FLAG1: sfr_mux = flag1_reg;
      ipc_pkg::ADDR_PRI2:  sfr_mux = pri2_reg;
      ipc_pkg::ADDR_PRI1:  sfr_mux = pri1_reg;
      default:             sfr_mux = 8'h00;
    endcase
    case (sec_addr)
      ipc_pkg::ADDR_SEL1: sec_mux = sel1_reg;
      ipc_pkg::ADDR_SEL2: sec_mux = sel2_reg;
      ipc_pkg::ADDR_SEL3: sec_mux = sel3_reg;
      ipc_pkg::ADDR_SEL4: sec_mux = sel4_reg;
      ipc_pkg::ADDR_SEL5: sec_mux = sel5_reg;
      ipc_pkg::ADDR_CON1: sec_mux = con1_reg;
      ipc_pkg::ADDR_CON2: sec_mux = con2_reg;
      default:            sec_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sfr_rdata_reg <= 8'h00;
      sec_rdata_reg <= 8'h00;
    end else begin
      if (sfr_rd) begin
        sfr_rdata_reg <= sfr_mux;
      end
      if (sec_rd) begin
        sec_rdata_reg <= sec_mux;
      end
    end
  end

  assign sfr_rdata   = sfr_rdata_reg;
  assign sec_rdata   = sec_rdata_reg;
  assign irq_take    = take_reg;
  assign irq_vector  = vec_reg;
  assign irq_level   = level_reg;
  assign active_high = act_high_reg;
  assign active_low  = act_low_reg;
  assign ext0_flag   = ext0_flag_reg;
  assign ext1_flag   = ext1_flag_reg;

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_global_gate: assert property (irq_take |->
    $past(en0_reg[ipc_pkg::BIT_GLOBAL_EN]))
    else $error("take with global enable off");
  a_source_enab: assert property (irq_take |-> $past(|(pend_lat_reg & enab)))
    else $error("take with no enabled source");
  a_high_first: assert property (irq_take && !irq_level |->
    $past(hi == '0))
    else $error("low taken over pending high");
  a_no_preempt: assert property (irq_take |-> !$past(act_high_reg))
    else $error("high routine preempted");
  a_reti_restore: assert property (instr_done && instr_is_reti
    && act_high_reg && !do_take |=> !act_high_reg)
    else $error("return did not drop high level");
  a_reti_holdoff: assert property (instr_done && instr_is_reti |=>
    !irq_take)
    else $error("taken straight after return");
  a_call_length: assert property (irq_take |->
    call_cnt_reg == ipc_pkg::LCALL_CYCLES ##1 !irq_take)
    else $error("long call count wrong");
  a_sample_c1: assert property (!first_clock_of_cycle |=>
    $stable(samp_reg))
    else $error("pins sampled off first clock");
  a_legacy_edge: assert property (!ext0_trigger_type && fall[0] |=>
    ext0_flag)
    else $error("falling legacy edge lost");
  a_status_set: assert property (status_set[6] |=> pstat_reg[6])
    else $error("status set lost to clear");
  a_pin_clear: assert property (w_sel2 && !sec_wdata[0] && !g0_evt[0]
    |=> !xstat_reg[0])
    else $error("pin status not cleared by select");

  c_take_high: cover property (irq_take && irq_level);
  c_take_low:  cover property (irq_take && !irq_level);
  c_preempt:   cover property (irq_take && irq_level && $past(act_low_reg));
  c_hold:      cover property (state_reg == ipc_pkg::ST_HOLD ##1 irq_take);
endmodule : ipc_top
`default_nettype wire

/* File: ipc_pkg.sv */
// Behaviour
// - Global enable bit 7 of first enable register masks every request when 0.
// - First enable register gates timer1, ext1, timer0, ext0 at bits 3..0.
// - Second enable register gates wdt/timer2, scan, adc, i2c, ext2; rest reserved.
// - Second flag register holds ext4, ext3, spi, timer3, serial ports, low-voltage flags.
// - First priority register bits 3..0 choose high level when 1.
// - High-level requests win; equal levels resolve by the fixed default order.
// - Low service preempted only by high; high service never preempted.
// - Return from interrupt resumes program and restores the previous active level.
// - Respond at instruction end; after return or enable/priority access, one more.
// - Least response is five cycles: one detect, four for the long call.
// - Worst response is thirteen cycles: detect, return, multiply/divide, call.
// - External inputs sampled at end of first clock of each instruction cycle.
// - Legacy input active low; type bit 0 gives falling-edge flag, 1 level.
// - Peripheral status bits set on event, clear on write 0 or config writes.
// - Pin-8 status at bit 5 clears on write 0 or its select written 0.
// - Group-0 pin status bits clear on write 0 or select bit cleared.
// - Two-bit polarity: 01 falling, 10 rising, 00 or 11 both edges.
// - Ext4 group polarity bit: 1 rising edge, 0 falling edge.
package ipc_pkg;
  localparam int NUM_SRC = 17;
  localparam int PIN_W   = 30;
  // SFR space
  localparam logic [7:0] ADDR_EN0   = 8'hA8;
  localparam logic [7:0] ADDR_PSTAT = 8'hAE;
  localparam logic [7:0] ADDR_PRI0  = 8'hB8;
  localparam logic [7:0] ADDR_XSTAT = 8'hC7;
  localparam logic [7:0] ADDR_FLAG2 = 8'hE1;
  localparam logic [7:0] ADDR_EN1   = 8'hE6;
  localparam logic [7:0] ADDR_EN2   = 8'hE7;
  localparam logic [7:0] ADDR_FLAG1 = 8'hF1;
  localparam logic [7:0] ADDR_PRI2  = 8'hF4;
  localparam logic [7:0] ADDR_PRI1  = 8'hF6;
  // Secondary space
  localparam logic [7:0] ADDR_SEL1 = 8'h34;
  localparam logic [7:0] ADDR_SEL2 = 8'h35;
  localparam logic [7:0] ADDR_SEL3 = 8'h36;
  localparam logic [7:0] ADDR_SEL4 = 8'h37;
  localparam logic [7:0] ADDR_SEL5 = 8'h38;
  localparam logic [7:0] ADDR_CON1 = 8'h39;
  localparam logic [7:0] ADDR_CON2 = 8'h3A;
  // Implemented bits
  localparam logic [7:0] MASK_EN0   = 8'h8F;
  localparam logic [7:0] MASK_PRI0  = 8'h0F;
  localparam logic [7:0] MASK_GRP1  = 8'hDC;
  localparam logic [7:0] MASK_PSTAT = 8'h7B;
  localparam logic [7:0] MASK_SEL3  = 8'h80;
  localparam logic [7:0] MASK_SEL5  = 8'h7F;
  localparam logic [7:0] MASK_CON2  = 8'h07;
  localparam logic [7:0] RST_ZERO   = 8'h00;
  localparam logic [7:0] RST_SEL1   = 8'h10;
  localparam logic [7:0] RST_CON1   = 8'h55;
  localparam logic [7:0] RST_CON2   = 8'h01;
  localparam int BIT_GLOBAL_EN = 7;
  localparam int BIT_PIN8_STAT = 5;
  // Polarity codes
  localparam logic [1:0] POL_FALL = 2'h1;
  localparam logic [1:0] POL_RISE = 2'h2;
  // Response timing in instruction cycles
  localparam int DETECT_CYCLES = 1;
  localparam int RETI_CYCLES   = 3;
  localparam int MULDIV_CYCLES = 5;
  localparam logic [2:0] LCALL_CYCLES = 3'h4;
  localparam int WORST_CYCLES  = DETECT_CYCLES + RETI_CYCLES
                                 + MULDIV_CYCLES + 4;
  localparam int PIN_HOLD_CLKS = 2;
  // Vector numbering gaps
  localparam logic [4:0] GAP_A = 5'h05;
  localparam logic [4:0] GAP_B = 5'h06;
  localparam logic [2:0] VEC_LOW = 3'h3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_HOLD = 3'h2,
    ST_CALL = 3'h4
  } ipc_state_t;

  function automatic logic [15:0] ipc_vector(input logic [4:0] idx);
    logic [4:0] num;
    num = idx;
    if (idx > 5'h6) begin
      num = idx + GAP_B;
    end else if (idx > 5'h3) begin
      num = idx + GAP_A;
    end
    return {8'h00, num, VEC_LOW};
  endfunction : ipc_vector
endpackage : ipc_pkg

/* File: ipc_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ipc_cpu_model (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // Bench asks for a return instruction
  input  wire logic reti_req,
  // Sequencer side
  output logic      first_clock_of_cycle,
  output logic      instr_done,
  output logic      instr_is_reti
);
  // Two clocks per instruction keeps sampling and boundary apart
  logic phase_reg;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) phase_reg <= 1'b0;
    else phase_reg <= ~phase_reg;
  end
  assign first_clock_of_cycle = ~rst & ~phase_reg;
  assign instr_done = ~rst & phase_reg;
  assign instr_is_reti = instr_done & reti_req;
endmodule : ipc_cpu_model
`default_nettype wire

/* File: ipc_top_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module ipc_top_tb_top;
  logic        clk_sys, rst, sfr_wr, sfr_rd, sec_wr, sec_rd, reti_req;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, sec_addr, sec_wdata;
  logic [7:0]  sec_rdata, flag1_set, flag2_set, status_set, group0_pins;
  logic        first_clock_of_cycle, instr_done, instr_is_reti, irq_take;
  logic        irq_level, active_high, active_low, ext0_flag, ext1_flag;
  logic [15:0] irq_vector, ext4_pins;
  logic        timer0_overflow_flag, timer1_overflow_flag, ext0_trigger_type;
  logic        ext1_trigger_type, ext0_flag_clr, ext1_flag_clr;
  logic        timer3_config_write, timer2_config_write, scan_start_write;
  logic        watchdog_control_write, legacy_external_pin_0;
  logic        legacy_external_pin_1;
  int          errors, check_count;
  // ====================
  // Design and sequencer
  ipc_top u_dut (.clk_sys, .rst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
    .sfr_rdata, .sec_addr, .sec_wr, .sec_rd, .sec_wdata, .sec_rdata,
    .first_clock_of_cycle, .instr_done, .instr_is_reti, .irq_take,
    .irq_vector, .irq_level, .active_high, .active_low,
    .timer0_overflow_flag, .timer1_overflow_flag, .ext0_trigger_type,
    .ext1_trigger_type, .ext0_flag_clr, .ext1_flag_clr, .ext0_flag,
    .ext1_flag, .flag1_set, .flag2_set, .status_set, .timer3_config_write,
    .timer2_config_write, .watchdog_control_write, .scan_start_write,
    .legacy_external_pin_0, .legacy_external_pin_1, .group0_pins,
    .group0_pin8(1'b1), .ext1_pin(1'b1), .ext2_pin(1'b1), .ext3_pin(1'b1),
    .ext4_pins);
  ipc_cpu_model u_cpu (.clk_sys, .rst, .reti_req, .first_clock_of_cycle,
    .instr_done, .instr_is_reti);
  // ====================
  // Tasks
  task automatic cmp(input string n, input logic [15:0] e, g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  task automatic acc(input logic s, w, input logic [7:0] a, d);
    @(posedge clk_sys); #1;
    {sec_addr, sfr_addr, sec_wdata, sfr_wdata} = {a, a, d, d};
    {sec_wr, sec_rd, sfr_wr, sfr_rd} = {s & w, s & ~w, ~s & w, ~s & ~w};
    @(posedge clk_sys); #1;
    {sec_wr, sec_rd, sfr_wr, sfr_rd} = 4'h0;
  endtask : acc
  task automatic rd(input logic s, input logic [7:0] a, e);
    acc(s, 1'b0, a, 8'h00);
    cmp("rdata", {8'h00, e}, {8'h00, s ? sec_rdata : sfr_rdata});
  endtask : rd
  task automatic take(input logic [15:0] v, input logic l);
    int i;
    for (i = 0; i < 40 && irq_take !== 1'b1; i++) begin
      @(posedge clk_sys); #1;
    end
    cmp("take", 16'h0001, {15'h0, irq_take});
    cmp("vector", v, irq_vector);
    cmp("level", {15'h0, l}, {15'h0, irq_level});
  endtask : take
  task automatic idle(input int n);
    int hits;
    hits = 0;
    repeat (n) begin
      @(posedge clk_sys); #1;
      if (irq_take === 1'b1) hits++;
    end
    cmp("no take", 16'h0, hits[15:0]);
  endtask : idle
  // Ends just after the boundary edge so a take right after is not missed
  task automatic reti;
    @(posedge clk_sys); #1;
    reti_req = 1'b1;
    if (instr_done !== 1'b1) begin
      @(posedge clk_sys); #1;
    end
    @(posedge clk_sys); #1;
    reti_req = 1'b0;
  endtask : reti
  task automatic complete_run;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run
  // ====================
  // Clock, watchdog, tests
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial begin
    // Far beyond the under two hundred cycles the tests need
    repeat (3000) @(posedge clk_sys);
    errors++;
    complete_run();
  end
  initial begin
    {sfr_wr, sfr_rd, sec_wr, sec_rd, reti_req, ext0_flag_clr} = '0;
    {sfr_addr, sfr_wdata, sec_addr, sec_wdata, flag1_set, flag2_set} = '0;
    {status_set, timer0_overflow_flag, timer1_overflow_flag} = '0;
    {ext0_trigger_type, ext1_trigger_type, ext1_flag_clr} = '0;
    {timer3_config_write, timer2_config_write, scan_start_write} = '0;
    watchdog_control_write = 1'b0;
    {legacy_external_pin_0, legacy_external_pin_1, group0_pins} = '1;
    ext4_pins = '1;
    rst = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1 rst = 1'b0;
    rd(1'b1, 8'h34, 8'h10);
    rd(1'b1, 8'h39, 8'h55);
    rd(1'b1, 8'h3A, 8'h01);
    acc(1'b0, 1'b1, 8'hA8, 8'hFF);
    rd(1'b0, 8'hA8, 8'h8F);
    rd(1'b0, 8'h00, 8'h00);
    acc(1'b0, 1'b1, 8'hA8, 8'h02);
    timer0_overflow_flag = 1'b1;
    idle(30);
    acc(1'b0, 1'b1, 8'hA8, 8'h8A);
    take(16'h000B, 1'b0);
    cmp("active_low", 16'h1, {15'h0, active_low});
    timer1_overflow_flag = 1'b1;
    idle(20);
    acc(1'b0, 1'b1, 8'hB8, 8'h08);
    take(16'h001B, 1'b1);
    idle(20);
    timer1_overflow_flag = 1'b0;
    reti();
    cmp("active_high", 16'h0, {15'h0, active_high});
    cmp("active_low", 16'h1, {15'h0, active_low});
    reti();
    take(16'h000B, 1'b0);
    acc(1'b0, 1'b1, 8'hF4, 8'h01);
    acc(1'b0, 1'b1, 8'hE7, 8'h01);
    flag2_set = 8'h01;
    @(posedge clk_sys);
    #1 flag2_set = 8'h00;
    take(16'h007B, 1'b1);
    ext1_trigger_type = 1'b1;
    {legacy_external_pin_0, legacy_external_pin_1} = 2'b00;
    repeat (8) @(posedge clk_sys);
    #1 cmp("ext0_flag", 16'h1, {15'h0, ext0_flag});
    cmp("ext1_flag", 16'h1, {15'h0, ext1_flag});
    acc(1'b1, 1'b1, 8'h35, 8'h01);
    acc(1'b1, 1'b1, 8'h36, 8'h80);
    group0_pins = 8'hFE;
    ext4_pins = 16'hFFFE;
    repeat (8) @(posedge clk_sys);
    rd(1'b0, 8'hC7, 8'h01);
    rd(1'b0, 8'hE1, 8'h81);
    acc(1'b1, 1'b1, 8'h35, 8'h00);
    rd(1'b0, 8'hC7, 8'h00);
    status_set = 8'h40;
    @(posedge clk_sys);
    #1 status_set = 8'h00;
    rd(1'b0, 8'hAE, 8'h40);
    acc(1'b0, 1'b1, 8'hAE, 8'h00);
    rd(1'b0, 8'hAE, 8'h00);
    complete_run();
  end
endmodule : ipc_top_tb_top
`default_nettype wire
